/* File: design/lgt_pkg.sv */
package lgt_pkg;

   localparam int DATA_W = 32;
   localparam int ADDR_W = 32;

   // Register byte addresses
   localparam logic [31:0] T0_LOAD_ADDR = 32'hFFFF0300;
   localparam logic [31:0] T0_CNT_LO_ADDR = 32'hFFFF0304;
   localparam logic [31:0] T0_CNT_HI_ADDR = 32'hFFFF0308;
   localparam logic [31:0] T0_CTRL_ADDR = 32'hFFFF030C;
   localparam logic [31:0] T0_CLEAR_ADDR = 32'hFFFF0310;
   localparam logic [31:0] T0_CAP_ADDR = 32'hFFFF0314;
   localparam logic [31:0] T1_LOAD_ADDR = 32'hFFFF0320;
   localparam logic [31:0] T1_CNT_ADDR = 32'hFFFF0324;
   localparam logic [31:0] T1_CTRL_ADDR = 32'hFFFF0328;
   localparam logic [31:0] T1_CLEAR_ADDR = 32'hFFFF032C;
   localparam logic [31:0] T1_CAP_ADDR = 32'hFFFF0330;

   // Reset values and writable-bit masks
   localparam logic [31:0] T0_CTRL_RESET = 32'h00000000;
   localparam logic [31:0] T0_CTRL_WMASK = 32'h0003F7DF;
   localparam logic [31:0] T1_CTRL_RESET = 32'h01000000;
   localparam logic [31:0] T1_CTRL_WMASK = 32'hFF87FFFF;
   localparam logic [31:0] T1_CNT_RESET = 32'h0FFFFFFF;
   localparam logic [7:0] POST_RESET = 8'h01;
   localparam logic [7:0] POST_ONE = 8'h01;

   // Prescaler codes and matching count masks
   localparam logic [3:0] PRE_DIV16 = 4'h4;
   localparam logic [3:0] PRE_DIV256 = 4'h8;
   localparam logic [3:0] PRE_DIV32K = 4'hF;
   localparam logic [14:0] PRE_MASK1 = 15'h0000;
   localparam logic [14:0] PRE_MASK16 = 15'h000F;
   localparam logic [14:0] PRE_MASK256 = 15'h00FF;
   localparam logic [14:0] PRE_MASK32K = 15'h7FFF;

   // Clock source selections
   localparam logic [1:0] T0_SRC_CORE = 2'h0;
   localparam logic [1:0] T0_SRC_LP = 2'h1;
   localparam logic [1:0] T0_SRC_XTAL = 2'h2;
   localparam logic [1:0] T0_SRC_PREC = 2'h3;
   localparam logic [2:0] T1_SRC_LP = 3'h1;
   localparam logic [2:0] T1_SRC_GPIO8 = 3'h2;
   localparam logic [2:0] T1_SRC_GPIO5 = 3'h3;

   // Index of each source in the synchroniser bank
   localparam int NUM_SRC = 5;
   localparam int SRC_LP = 0;
   localparam int SRC_XTAL = 1;
   localparam int SRC_PREC = 2;
   localparam int SRC_GPIO8 = 3;
   localparam int SRC_GPIO5 = 4;

   // Count formats and time-of-day limits
   localparam logic [1:0] FMT_TOD255 = 2'h3;
   localparam logic [7:0] HUND_MAX = 8'h63;
   localparam logic [7:0] SEC_MAX = 8'h3B;
   localparam logic [7:0] MIN_MAX = 8'h3B;
   localparam logic [7:0] HR23_MAX = 8'h17;
   localparam logic [7:0] HR255_MAX = 8'hFF;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [13:0] rsvd_hi;
      logic cap_en;
      logic [4:0] cap_sel;
      logic rsvd_11;
      logic [1:0] clk_sel;
      logic count_up;
      logic enable;
      logic periodic;
      logic rsvd_5;
      logic wide;
      logic [3:0] prescale;
   } lgt_t0_ctrl_t;

   typedef struct packed {
      logic [7:0] post_target;
      logic post_en;
      logic [2:0] rsvd;
      logic post_flag;
      logic irq_from_post;
      logic cap_en;
      logic [4:0] cap_sel;
      logic [2:0] clk_sel;
      logic count_up;
      logic enable;
      logic periodic;
      logic [1:0] format;
      logic [3:0] prescale;
   } lgt_t1_ctrl_t;

endpackage

/* File: design/lgt_timers.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Settings reach counters via two-stage timer-clock sync
// - Lifetime control bit 4 selects 16/48 bits
// - 48-bit mode counts up from zero
// - Bit 8 direction; load/capture/clear 16-bit only
// - Lifetime bits 10:9 pick clock source
// - Bits 3:0 prescale by 1/16/256/32768
// - Bit 7 enables lifetime counting
// - Bit 6 periodic, else free-running
// - Lifetime reloads load value on overflow in periodic mode
// - Bit 17 enables capture on selected event
// - Write to lifetime clear in 16-bit mode drops interrupt unless a timeout sets it in that cycle
// - General timer 32-bit, four sources, prescaled
// - General count binary or time-of-day
// - General timer captures count on event
// - Postscaler counts 1 to 255 timeouts
// - General keeps counting in low power unless clocked from core
// - General reloads load value on overflow in periodic mode
// - Write to general clear drops interrupt unless the interrupt sets in that cycle
// - Interrupt at zero down, full scale up
// - Periodic reloads; free-running rolls over
// - Format 00 binary, 10/11 time-of-day
module lgt_timers
   import lgt_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic lp_osc,
   input wire logic watch_xtal,
   input wire logic prec_osc,
   input wire logic gpio5,
   input wire logic gpio8,
   input wire logic low_power,
   input wire logic [31:0] event_src,
   output logic lifetime_irq,
   output logic general_irq
);

   function automatic logic hit(input logic [31:0] a, input logic [31:0] b);
      return a[31:2] == b[31:2];
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      return (old & ~m) | (nw & m);
   endfunction

   function automatic logic [14:0] pre_mask(input logic [3:0] code);
      logic [14:0] m;
      m = PRE_MASK1;
      case (code)
         PRE_DIV16: m = PRE_MASK16;
         PRE_DIV256: m = PRE_MASK256;
         PRE_DIV32K: m = PRE_MASK32K;
         default: m = PRE_MASK1;
      endcase
      return m;
   endfunction

   function automatic logic [31:0] tod_max(input logic [1:0] fmt);
      return {(fmt == FMT_TOD255) ? HR255_MAX : HR23_MAX, MIN_MAX, SEC_MAX, HUND_MAX};
   endfunction

   // Binary or time-of-day step with carry/borrow between fields
   function automatic logic [31:0] t1_next(input logic [31:0] v, input logic up,
                                           input logic [1:0] fmt);
      logic [31:0] lim;
      logic [31:0] r;
      logic c;
      lim = tod_max(fmt);
      r = v;
      c = 1'b1;
      if (!fmt[1]) begin
         r = up ? v + 32'h00000001 : v - 32'h00000001;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (c) begin
               if (up) begin
                  c = (v[i*8 +: 8] == lim[i*8 +: 8]);
                  r[i*8 +: 8] = c ? 8'h00 : v[i*8 +: 8] + 8'h01;
               end else begin
                  c = (v[i*8 +: 8] == 8'h00);
                  r[i*8 +: 8] = c ? lim[i*8 +: 8] : v[i*8 +: 8] - 8'h01;
               end
            end
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Source clock synchronisers and tick detection

   logic [NUM_SRC-1:0] src_in;
   logic [NUM_SRC-1:0] src_meta_reg;
   logic [NUM_SRC-1:0] src_sync_reg;
   logic [NUM_SRC-1:0] src_last_reg;
   logic [NUM_SRC-1:0] src_tick;
   logic core_tick;

   assign src_in = {gpio5, gpio8, prec_osc, watch_xtal, lp_osc};

   for (genvar gi = 0; gi < NUM_SRC; gi++) begin : g_src
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            src_meta_reg[gi] <= 1'b0;
            src_sync_reg[gi] <= 1'b0;
            src_last_reg[gi] <= 1'b0;
         end else begin
            src_meta_reg[gi] <= src_in[gi];
            src_sync_reg[gi] <= src_meta_reg[gi];
            src_last_reg[gi] <= src_sync_reg[gi];
         end
      end
      assign src_tick[gi] = src_sync_reg[gi] & ~src_last_reg[gi];
   end

   // Core clock stops in low power; oscillator and pin sources keep running
   assign core_tick = ~low_power;

   logic [31:0] event_last_reg;
   logic [31:0] ev_rise;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         event_last_reg <= 32'h00000000;
      end else begin
         event_last_reg <= event_src;
      end
   end

   assign ev_rise = event_src & ~event_last_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave

   logic aw_hold_reg;
   logic w_hold_reg;
   logic [31:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rdata_reg;
   logic wr_go;
   logic wr_mapped;
   logic [31:0] rd_data;
   logic rd_mapped;

   assign s_axi_awready = ~aw_hold_reg & ~bvalid_reg;
   assign s_axi_wready = ~w_hold_reg & ~bvalid_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = ~rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;
   assign wr_go = aw_hold_reg & w_hold_reg & ~bvalid_reg;

   always_comb begin
      wr_mapped = 1'b0;
      for (int i = 0; i < 12; i++) begin
         if (hit(awaddr_reg, T0_LOAD_ADDR + 32'(i * 4)) && i != 6 && i != 7) begin
            wr_mapped = 1'b1;
         end
      end
      if (hit(awaddr_reg, T1_CAP_ADDR)) begin
         wr_mapped = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         awaddr_reg <= 32'h00000000;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= 32'h00000000;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_reg <= 1'b1;
         rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
         rdata_reg <= rd_data;
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Software-side registers

   logic [15:0] t0_load_reg;
   lgt_t0_ctrl_t t0_ctrl_reg;
   logic [31:0] t1_load_reg;
   lgt_t1_ctrl_t t1_ctrl_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         t0_load_reg <= 16'h0000;
         t0_ctrl_reg <= lgt_t0_ctrl_t'(T0_CTRL_RESET);
         t1_load_reg <= 32'h00000000;
         t1_ctrl_reg <= lgt_t1_ctrl_t'(T1_CTRL_RESET);
      end else if (wr_go) begin
         if (hit(awaddr_reg, T0_LOAD_ADDR)) begin
            t0_load_reg <= 16'(merge({16'h0000, t0_load_reg}, wdata_reg, wstrb_reg));
         end
         if (hit(awaddr_reg, T0_CTRL_ADDR)) begin
            t0_ctrl_reg <= lgt_t0_ctrl_t'(merge(t0_ctrl_reg, wdata_reg, wstrb_reg)
                                          & T0_CTRL_WMASK);
         end
         if (hit(awaddr_reg, T1_LOAD_ADDR)) begin
            t1_load_reg <= merge(t1_load_reg, wdata_reg, wstrb_reg);
         end
         if (hit(awaddr_reg, T1_CTRL_ADDR)) begin
            t1_ctrl_reg <= lgt_t1_ctrl_t'(merge(t1_ctrl_reg, wdata_reg, wstrb_reg)
                                          & T1_CTRL_WMASK);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Lifetime timer

   lgt_t0_ctrl_t t0_ctrl_s1_reg;
   lgt_t0_ctrl_t t0_ctrl_s2_reg;
   logic [15:0] t0_load_s1_reg;
   logic [15:0] t0_load_s2_reg;
   logic t0_tick;
   logic t0_run_reg;
   logic [14:0] t0_pre_reg;
   logic [14:0] t0_mask;
   logic [47:0] t0_cnt_reg;
   logic [15:0] t0_lo;
   logic [15:0] t0_lo_next;
   logic t0_start;
   logic t0_step;
   logic t0_ext;
   logic t0_timeout;
   logic t0_clear;
   logic t0_irq_reg;
   logic [15:0] t0_cap_reg;

   always_comb begin
      unique case (t0_ctrl_reg.clk_sel)
         T0_SRC_CORE: t0_tick = core_tick;
         T0_SRC_LP: t0_tick = src_tick[SRC_LP];
         T0_SRC_XTAL: t0_tick = src_tick[SRC_XTAL];
         T0_SRC_PREC: t0_tick = src_tick[SRC_PREC];
      endcase
   end

   // Settings advance one stage per selected source tick
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         t0_ctrl_s1_reg <= lgt_t0_ctrl_t'(T0_CTRL_RESET);
         t0_ctrl_s2_reg <= lgt_t0_ctrl_t'(T0_CTRL_RESET);
         t0_load_s1_reg <= 16'h0000;
         t0_load_s2_reg <= 16'h0000;
      end else if (t0_tick) begin
         t0_ctrl_s1_reg <= t0_ctrl_reg;
         t0_ctrl_s2_reg <= t0_ctrl_s1_reg;
         t0_load_s1_reg <= t0_load_reg;
         t0_load_s2_reg <= t0_load_s1_reg;
      end
   end

   assign t0_mask = pre_mask(t0_ctrl_s2_reg.prescale);
   assign t0_start = t0_tick & t0_ctrl_s2_reg.enable & ~t0_run_reg;
   assign t0_step = t0_tick & t0_ctrl_s2_reg.enable & t0_run_reg
                    & ((t0_pre_reg & t0_mask) == t0_mask);
   assign t0_lo = t0_cnt_reg[15:0];
   assign t0_ext = t0_ctrl_s2_reg.count_up ? (t0_lo == 16'hFFFF) : (t0_lo == 16'h0000);
   assign t0_timeout = t0_step & ~t0_ctrl_s2_reg.wide & t0_ext;
   assign t0_clear = wr_go & hit(awaddr_reg, T0_CLEAR_ADDR) & ~t0_ctrl_reg.wide;

   always_comb begin
      if (t0_ext && t0_ctrl_s2_reg.periodic) begin
         t0_lo_next = t0_load_s2_reg;
      end else if (t0_ctrl_s2_reg.count_up) begin
         t0_lo_next = t0_lo + 16'h0001;
      end else begin
         t0_lo_next = t0_lo - 16'h0001;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         t0_run_reg <= 1'b0;
      end else if (t0_tick) begin
         t0_run_reg <= t0_ctrl_s2_reg.enable;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         t0_pre_reg <= 15'h0000;
      end else if (t0_start) begin
         t0_pre_reg <= 15'h0000;
      end else if (t0_tick && t0_run_reg && t0_ctrl_s2_reg.enable) begin
         t0_pre_reg <= t0_pre_reg + 15'h0001;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         t0_cnt_reg <= 48'h000000000000;
      end else if (t0_start) begin
         t0_cnt_reg <= t0_ctrl_s2_reg.wide ? 48'h000000000000 : {32'h00000000, t0_load_s2_reg};
      end else if (t0_step) begin
         if (t0_ctrl_s2_reg.wide) begin
            t0_cnt_reg <= t0_cnt_reg + 48'h000000000001;
         end else begin
            t0_cnt_reg <= {32'h00000000, t0_lo_next};
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         t0_irq_reg <= 1'b0;
      end else if (t0_timeout) begin
         t0_irq_reg <= 1'b1;
      end else if (t0_clear) begin
         t0_irq_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         t0_cap_reg <= 16'h0000;
      end else if (t0_ctrl_s2_reg.cap_en && !t0_ctrl_s2_reg.wide
                   && ev_rise[t0_ctrl_s2_reg.cap_sel]) begin
         t0_cap_reg <= t0_lo;
      end else if (wr_go && hit(awaddr_reg, T0_CAP_ADDR)) begin
         t0_cap_reg <= 16'(merge({16'h0000, t0_cap_reg}, wdata_reg, wstrb_reg));
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // General timer

   lgt_t1_ctrl_t t1_ctrl_s1_reg;
   lgt_t1_ctrl_t t1_ctrl_s2_reg;
   logic [31:0] t1_load_s1_reg;
   logic [31:0] t1_load_s2_reg;
   logic t1_tick;
   logic t1_run_reg;
   logic [14:0] t1_pre_reg;
   logic [14:0] t1_mask;
   logic [31:0] t1_cnt_reg;
   logic t1_start;
   logic t1_step;
   logic t1_ext;
   logic t1_timeout;
   logic [7:0] t1_target;
   logic [7:0] t1_post_reg;
   logic t1_post_hit;
   logic t1_post_on;
   logic t1_flag_reg;
   logic t1_clear;
   logic t1_irq_reg;
   logic [31:0] t1_cap_reg;

   always_comb begin
      case (t1_ctrl_reg.clk_sel)
         T1_SRC_LP: t1_tick = src_tick[SRC_LP];
         T1_SRC_GPIO8: t1_tick = src_tick[SRC_GPIO8];
         T1_SRC_GPIO5: t1_tick = src_tick[SRC_GPIO5];
         default: t1_tick = core_tick;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         t1_ctrl_s1_reg <= lgt_t1_ctrl_t'(T1_CTRL_RESET);
         t1_ctrl_s2_reg <= lgt_t1_ctrl_t'(T1_CTRL_RESET);
         t1_load_s1_reg <= 32'h00000000;
         t1_load_s2_reg <= 32'h00000000;
      end else if (t1_tick) begin
         t1_ctrl_s1_reg <= t1_ctrl_reg;
         t1_ctrl_s2_reg <= t1_ctrl_s1_reg;
         t1_load_s1_reg <= t1_load_reg;
         t1_load_s2_reg <= t1_load_s1_reg;
      end
   end

   assign t1_mask = pre_mask(t1_ctrl_s2_reg.prescale);
   assign t1_start = t1_tick & t1_ctrl_s2_reg.enable & ~t1_run_reg;
   assign t1_step = t1_tick & t1_ctrl_s2_reg.enable & t1_run_reg
                    & ((t1_pre_reg & t1_mask) == t1_mask);
   assign t1_ext = t1_ctrl_s2_reg.count_up
                   ? (t1_cnt_reg == (t1_ctrl_s2_reg.format[1] ? tod_max(t1_ctrl_s2_reg.format)
                                                              : 32'hFFFFFFFF))
                   : (t1_cnt_reg == 32'h00000000);
   assign t1_timeout = t1_step & t1_ext;
   assign t1_target = (t1_ctrl_s2_reg.post_target == 8'h00) ? POST_ONE
                      : t1_ctrl_s2_reg.post_target;
   // Either enable bit or postscaler interrupt source runs the postscaler
   assign t1_post_on = t1_ctrl_s2_reg.post_en | t1_ctrl_s2_reg.irq_from_post;
   assign t1_post_hit = t1_timeout & t1_post_on & (t1_post_reg >= t1_target);
   assign t1_clear = wr_go & hit(awaddr_reg, T1_CLEAR_ADDR);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         t1_run_reg <= 1'b0;
      end else if (t1_tick) begin
         t1_run_reg <= t1_ctrl_s2_reg.enable;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         t1_pre_reg <= 15'h0000;
      end else if (t1_start) begin
         t1_pre_reg <= 15'h0000;
      end else if (t1_tick && t1_run_reg && t1_ctrl_s2_reg.enable) begin
         t1_pre_reg <= t1_pre_reg + 15'h0001;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         t1_cnt_reg <= T1_CNT_RESET;
      end else if (t1_start) begin
         t1_cnt_reg <= t1_load_s2_reg;
      end else if (t1_step) begin
         if (t1_ext && t1_ctrl_s2_reg.periodic) begin
            t1_cnt_reg <= t1_load_s2_reg;
         end else begin
            t1_cnt_reg <= t1_next(t1_cnt_reg, t1_ctrl_s2_reg.count_up,
                                  t1_ctrl_s2_reg.format);
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         t1_post_reg <= POST_RESET;
      end else if (t1_timeout && t1_post_on) begin
         t1_post_reg <= t1_post_hit ? POST_ONE : t1_post_reg + 8'h01;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         t1_flag_reg <= 1'b0;
      end else if (t1_post_hit) begin
         t1_flag_reg <= 1'b1;
      end else if (t1_clear) begin
         t1_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         t1_irq_reg <= 1'b0;
      end else if (t1_ctrl_s2_reg.irq_from_post ? t1_post_hit : t1_timeout) begin
         t1_irq_reg <= 1'b1;
      end else if (t1_clear) begin
         t1_irq_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         t1_cap_reg <= 32'h00000000;
      end else if (t1_ctrl_s2_reg.cap_en && ev_rise[t1_ctrl_s2_reg.cap_sel]) begin
         t1_cap_reg <= t1_cnt_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read mux and outputs

   always_comb begin
      rd_data = 32'h00000000;
      rd_mapped = 1'b1;
      if (hit(s_axi_araddr, T0_LOAD_ADDR)) begin
         rd_data = {16'h0000, t0_load_reg};
      end else if (hit(s_axi_araddr, T0_CNT_LO_ADDR)) begin
         rd_data = {16'h0000, t0_lo};
      end else if (hit(s_axi_araddr, T0_CNT_HI_ADDR)) begin
         rd_data = t0_cnt_reg[47:16];
      end else if (hit(s_axi_araddr, T0_CTRL_ADDR)) begin
         rd_data = t0_ctrl_reg;
      end else if (hit(s_axi_araddr, T0_CAP_ADDR)) begin
         rd_data = {16'h0000, t0_cap_reg};
      end else if (hit(s_axi_araddr, T1_LOAD_ADDR)) begin
         rd_data = t1_load_reg;
      end else if (hit(s_axi_araddr, T1_CNT_ADDR)) begin
         rd_data = t1_cnt_reg;
      end else if (hit(s_axi_araddr, T1_CTRL_ADDR)) begin
         rd_data = {t1_post_reg, t1_ctrl_reg[23:20], t1_flag_reg, t1_ctrl_reg[18:0]};
      end else if (hit(s_axi_araddr, T1_CAP_ADDR)) begin
         rd_data = t1_cap_reg;
      end else if (!hit(s_axi_araddr, T0_CLEAR_ADDR) && !hit(s_axi_araddr, T1_CLEAR_ADDR)) begin
         rd_mapped = 1'b0;
      end
   end

   assign lifetime_irq = t0_irq_reg;
   assign general_irq = t1_irq_reg;

endmodule

/* File: tb/lgt_timers_monitor.sv */
`timescale 1ns/1ps
module lgt_timers_monitor
   import lgt_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic lifetime_irq,
   input wire logic general_irq
);
   logic [31:0] aw_q;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   always_ff @(posedge aclk) begin
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
   end
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write response dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read data dropped");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready busy");
   a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("awready busy");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read late");
   a_read_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 32'h0
      |=> s_axi_rresp == RESP_SLVERR) else $error("unmapped read okay");
   a_gen_clear: assert property ($rose(s_axi_bvalid) && aw_q == T1_CLEAR_ADDR
      |-> !general_irq) else $error("general irq not cleared");
   a_irq_reset: assert property ($rose(aresetn) |-> !lifetime_irq && !general_irq)
      else $error("irq after reset");
endmodule

/* File: tb/lgt_timers_tb.sv */
`timescale 1ns/1ps
module lgt_timers_tb;
   import lgt_pkg::*;
   logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, lp_osc = 1'h0;
   logic watch_xtal = 1'h0, prec_osc = 1'h0, gpio5 = 1'h0, gpio8 = 1'h0, low_power = 1'h0;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
   logic [31:0] event_src = 32'h0, s_axi_rdata, d, e;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic lifetime_irq, general_irq;
   int err_count = 0, checked = 0, n;
   lgt_timers i_dut (.*);
   always #20 aclk = ~aclk;
   always @(posedge aclk) lp_osc <= ~lp_osc;
   //////////////////////////////////////////////////////////////////////
   task tally_and_finish;
      if (err_count == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      checked++;
      if (x !== g) begin
         err_count++;
         $display("ERROR %s exp %h got %h", nm, x, g);
      end
   endtask
   task wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
      chk("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
   endtask
   task rd(input logic [31:0] a, input logic [1:0] r, output logic [31:0] v);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
      v = s_axi_rdata;
      chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
   endtask
   task wirq(input logic gen);
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (!(gen ? general_irq : lifetime_irq) && n < 200);
   endtask
   //////////////////////////////////////////////////////////////////////
   task t_reset;
      rd(T0_CTRL_ADDR, RESP_OKAY, d);
      chk("t0_ctrl", T0_CTRL_RESET, d);
      rd(T1_CNT_ADDR, RESP_OKAY, d);
      chk("t1_cnt", T1_CNT_RESET, d);
      rd(32'h0, RESP_SLVERR, d);
      chk("unmapped", 32'h0, d);
      wr(32'h0, 32'h0, RESP_SLVERR);
   endtask
   task t_life16;
      wr(T0_LOAD_ADDR, 32'h3, RESP_OKAY);
      wr(T0_CTRL_ADDR, 32'hC0, RESP_OKAY);
      wirq(1'h0);
      chk("lt_latency", 32'h1, {31'h0, n >= 6 && n <= 8});
      wr(T0_CTRL_ADDR, 32'h0, RESP_OKAY);
      wr(T0_CLEAR_ADDR, 32'h0, RESP_OKAY);
      chk("lt_irq_clr", 32'h0, {31'h0, lifetime_irq});
      rd(T0_CNT_LO_ADDR, RESP_OKAY, d);
      repeat (10) @(posedge aclk);
      rd(T0_CNT_LO_ADDR, RESP_OKAY, e);
      chk("lt_hold", d, e);
   endtask
   task t_life48;
      wr(T0_CTRL_ADDR, 32'h90, RESP_OKAY);
      repeat (40) @(posedge aclk);
      rd(T0_CNT_HI_ADDR, RESP_OKAY, d);
      chk("lt_hi48", 32'h0, d);
      rd(T0_CNT_LO_ADDR, RESP_OKAY, d);
      chk("lt_lo48", 32'h1, {31'h0, d >= 35 && d <= 48});
      chk("lt_irq48", 32'h0, {31'h0, lifetime_irq});
      wr(T0_CTRL_ADDR, 32'h0, RESP_OKAY);
   endtask
   task t_gen;
      wr(T1_LOAD_ADDR, 32'h20, RESP_OKAY);
      wr(T1_CTRL_ADDR, 32'h000230C0, RESP_OKAY);
      repeat (8) @(posedge aclk);
      wr(T1_CLEAR_ADDR, 32'h0, RESP_OKAY);
      event_src[3] <= 1'h1;
      rd(T1_CAP_ADDR, RESP_OKAY, d);
      chk("gt_cap", 32'h1, {31'h0, d >= 32'h10 && d <= 32'h20});
      repeat (40) @(posedge aclk);
      rd(T1_CAP_ADDR, RESP_OKAY, e);
      chk("gt_cap_once", d, e);
      wirq(1'h1);
      chk("gt_irq", 32'h1, {31'h0, general_irq});
      wr(T1_CTRL_ADDR, 32'h0, RESP_OKAY);
      wr(T1_CLEAR_ADDR, 32'h0, RESP_OKAY);
      chk("gt_irq_clr", 32'h0, {31'h0, general_irq});
      event_src[3] <= 1'h0;
   endtask
   task t_post;
      wr(T1_LOAD_ADDR, 32'hFFFFFFFD, RESP_OKAY);
      wr(T1_CTRL_ADDR, 32'h020401C0, RESP_OKAY);
      wirq(1'h1);
      chk("gt_post", 32'h9, n);
   endtask
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      t_reset;
      t_life16;
      t_life48;
      t_gen;
      t_post;
      tally_and_finish;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      err_count++;
      tally_and_finish;
   end
endmodule
bind lgt_timers lgt_timers_monitor i_mon (.*);
